// ### hw/fcs_device.sv
// Flash command sequencer: decodes CPU command writes and runs the operations.
`timescale 1ns/1ps
module fcs_device #(
  parameter int PROG_CYCLES = fcs_pkg::PROGRAM_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  fcs_if.device     bus,
  input  wire logic dataBlockAProtect,
  input  wire logic dataBlockBProtect,
  input  wire logic readyIrqEnable,
  input  wire logic suspendEnable,
  input  wire logic suspendRequest,
  input  wire logic lowCurrentReadEnable,
  output logic [7:0] flashStatus,
  output logic       busy,
  output logic       refreshActive
);
  fcs_pkg::fcs_state_type stateReg;
  logic [19:0] targetReg;
  logic [7:0]  firstCodeReg;
  logic [7:0]  dataReg;
  logic [7:0]  memReg [0:255];
  logic [1:0]  lockReg;
  logic [7:0]  refreshReg;
  logic [7:0]  statusReg;
  logic        opStart;
  logic        opDone;
  logic        isProgramOp;
  logic        progOk;
  logic        isRefreshAddr;

  // ------------------------------------------------------------------------
  // Address decoding helpers
  // ------------------------------------------------------------------------
  function automatic logic inRange(input logic [19:0] a, input logic [19:0] base,
                                   input logic [19:0] size);
    inRange = (a >= base) && (a < base + size);
  endfunction

  // Returns 0 for block 1, 1 for block 2; used to index lock bits.
  function automatic logic lockIndex(input logic [19:0] a);
    lockIndex = inRange(a, fcs_pkg::BLOCK2_START, fcs_pkg::BLOCK_SIZE);
  endfunction

  function automatic logic isRomBlock(input logic [19:0] a);
    isRomBlock = inRange(a, fcs_pkg::BLOCK1_START, fcs_pkg::BLOCK_SIZE)
              || inRange(a, fcs_pkg::BLOCK2_START, fcs_pkg::BLOCK_SIZE);
  endfunction

  function automatic logic isDataBlock(input logic [19:0] a);
    isDataBlock = inRange(a, fcs_pkg::DATA_A_START, fcs_pkg::DATA_BLOCK_SIZE)
               || inRange(a, fcs_pkg::DATA_B_START, fcs_pkg::DATA_BLOCK_SIZE);
  endfunction

  function automatic logic isBlockStart(input logic [19:0] a);
    isBlockStart = (a == fcs_pkg::BLOCK1_START) || (a == fcs_pkg::BLOCK2_START);
  endfunction

  // Refusal check for a program target.
  function automatic logic programRefused(input logic [19:0] a, input logic [1:0] lk,
                                          input logic pa, input logic pb);
    programRefused =
      (isRomBlock(a) && lk[lockIndex(a)])
      || (pa && inRange(a, fcs_pkg::DATA_A_START, fcs_pkg::DATA_BLOCK_SIZE))
      || (pb && inRange(a, fcs_pkg::DATA_B_START, fcs_pkg::DATA_BLOCK_SIZE));
  endfunction

  assign isRefreshAddr = (bus.addr == fcs_pkg::REFRESH_OFFSET);
  // A program fails when it would turn a cleared bit back into a one.
  assign progOk = !((dataReg & ~memReg[targetReg[7:0]]) != 8'h00);

  // ------------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------------
  // Writes to the refresh register address never count as flash commands.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stateReg     <= fcs_pkg::ST_READ_ARRAY;
      targetReg    <= 20'h00000;
      firstCodeReg <= 8'h00;
      dataReg      <= 8'h00;
      opStart      <= 1'b0;
      isProgramOp  <= 1'b0;
    end
    else
    begin
      opStart <= 1'b0;
      unique case (stateReg)
        fcs_pkg::ST_READ_ARRAY:
        begin
          if (bus.wrStrobe && !isRefreshAddr)
          begin
            firstCodeReg <= bus.wrData;
            targetReg    <= bus.addr;
            unique case (bus.wrData)
              fcs_pkg::CMD_PROGRAM: stateReg <= fcs_pkg::ST_WAIT_DATA;
              fcs_pkg::CMD_BLOCK_ERASE, fcs_pkg::CMD_BLANK_CHECK,
              fcs_pkg::CMD_LOCK_PROGRAM, fcs_pkg::CMD_LOCK_READ:
                stateReg <= fcs_pkg::ST_WAIT_CONF;
              default: stateReg <= fcs_pkg::ST_READ_ARRAY;
            endcase
          end
        end
        fcs_pkg::ST_WAIT_DATA:
        begin
          if (bus.wrStrobe && !isRefreshAddr)
          begin
            dataReg   <= bus.wrData;
            targetReg <= bus.addr;
            if (programRefused(bus.addr, lockReg, dataBlockAProtect, dataBlockBProtect))
            begin
              stateReg <= fcs_pkg::ST_READ_ARRAY;
            end
            else
            begin
              stateReg    <= fcs_pkg::ST_BUSY;
              isProgramOp <= 1'b1;
              opStart     <= 1'b1;
            end
          end
        end
        fcs_pkg::ST_WAIT_CONF:
        begin
          if (bus.wrStrobe && !isRefreshAddr)
          begin
            targetReg <= bus.addr;
            if (bus.wrData == fcs_pkg::CMD_READ_ARRAY)
            begin
              stateReg <= fcs_pkg::ST_READ_ARRAY;
            end
            else if (bus.wrData == fcs_pkg::CMD_CONFIRM &&
                     !(isDataBlock(bus.addr) &&
                       (firstCodeReg == fcs_pkg::CMD_LOCK_PROGRAM ||
                        firstCodeReg == fcs_pkg::CMD_LOCK_READ)))
            begin
              stateReg    <= fcs_pkg::ST_BUSY;
              isProgramOp <= 1'b0;
              opStart     <= 1'b1;
            end
            else
            begin
              stateReg <= fcs_pkg::ST_READ_ARRAY;
            end
          end
        end
        fcs_pkg::ST_BUSY:
        begin
          if (opDone)
          begin
            stateReg <= fcs_pkg::ST_READ_ARRAY;
          end
          else if (isProgramOp && suspendEnable && suspendRequest)
          begin
            stateReg <= fcs_pkg::ST_SUSPENDED;
          end
        end
        fcs_pkg::ST_SUSPENDED:
        begin
          if (!suspendRequest)
          begin
            stateReg <= fcs_pkg::ST_BUSY;
          end
        end
        default: stateReg <= fcs_pkg::ST_READ_ARRAY;
      endcase
    end
  end

  fcs_op_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (opStart),
    .hold  (stateReg == fcs_pkg::ST_SUSPENDED),
    .done  (opDone)
  );

  // ------------------------------------------------------------------------
  // Array contents and lock bits
  // ------------------------------------------------------------------------
  // Only the low address byte indexes this model array, keeping it small.
  // Reset starts it erased, so the first program has defined contents to check.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 256; i++)
      begin
        memReg[i] <= fcs_pkg::ERASED_BYTE;
      end
    end
    else if (opDone && isProgramOp)
    begin
      memReg[targetReg[7:0]] <= memReg[targetReg[7:0]] & dataReg;
    end
    else if (opDone && firstCodeReg == fcs_pkg::CMD_BLOCK_ERASE)
    begin
      memReg[targetReg[7:0]] <= fcs_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lockReg <= 2'b00;
    end
    else if (opDone && !isProgramOp && firstCodeReg == fcs_pkg::CMD_LOCK_PROGRAM
             && isBlockStart(targetReg))
    begin
      lockReg[lockIndex(targetReg)] <= 1'b1;
    end
  end

  // ------------------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------------------
  // Completion wins over a clear in the same cycle so no result is lost.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      statusReg <= fcs_pkg::STATUS_RESET;
    end
    else
    begin
      if (stateReg == fcs_pkg::ST_READ_ARRAY && bus.wrStrobe && !isRefreshAddr
          && bus.wrData == fcs_pkg::CMD_CLEAR_STATUS)
      begin
        statusReg[fcs_pkg::STAT_PROGRAM_BIT] <= 1'b0;
        statusReg[fcs_pkg::STAT_ERASE_BIT]   <= 1'b0;
      end
      // A resume is busy again, so it clears ready just like a fresh start.
      if (opStart || (stateReg == fcs_pkg::ST_SUSPENDED && !suspendRequest))
      begin
        statusReg[fcs_pkg::STAT_READY_BIT] <= 1'b0;
      end
      else if (opDone || stateReg == fcs_pkg::ST_SUSPENDED)
      begin
        statusReg[fcs_pkg::STAT_READY_BIT] <= 1'b1;
      end
      if (opDone && isProgramOp && !progOk)
      begin
        statusReg[fcs_pkg::STAT_PROGRAM_BIT] <= 1'b1;
      end
      if (opDone && !isProgramOp && firstCodeReg == fcs_pkg::CMD_LOCK_READ)
      begin
        statusReg[fcs_pkg::STAT_LOCK_BIT] <= !lockReg[lockIndex(targetReg)];
      end
    end
  end

  // ------------------------------------------------------------------------
  // Refresh interval register and read path
  // ------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      refreshReg <= fcs_pkg::REFRESH_RESET;
    end
    else if (bus.wrStrobe && isRefreshAddr)
    begin
      refreshReg <= {2'b00, bus.wrData[fcs_pkg::REFRESH_FIELD_W-1:0]};
    end
  end

  // Reads return the refresh register at its address, else the array in read mode and status while busy or pending.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus.rdData    <= 8'h00;
      bus.rdValid   <= 1'b0;
      bus.readyIrq  <= 1'b0;
      flashStatus   <= fcs_pkg::STATUS_RESET;
      busy          <= 1'b0;
      refreshActive <= 1'b0;
    end
    else
    begin
      bus.rdValid <= bus.rdStrobe;
      if (isRefreshAddr)
      begin
        bus.rdData <= refreshReg;
      end
      else if (stateReg == fcs_pkg::ST_READ_ARRAY)
      begin
        bus.rdData <= memReg[bus.addr[7:0]];
      end
      else
      begin
        bus.rdData <= statusReg;
      end
      bus.readyIrq <= readyIrqEnable &&
                      ((opDone && isProgramOp)
                       || (stateReg == fcs_pkg::ST_BUSY && isProgramOp
                           && suspendEnable && suspendRequest && !opDone));
      flashStatus   <= statusReg;
      busy          <= (stateReg == fcs_pkg::ST_BUSY);
      refreshActive <= lowCurrentReadEnable && (refreshReg != 8'h00);
    end
  end
endmodule // fcs_device

// ### hw/fcs_pkg.sv
// Package of shared constants and types for the flash command sequencer.
package fcs_pkg;

  // ------------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ    = 8'h71;
  localparam logic [7:0] CMD_BLANK_CHECK  = 8'h25;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;

  // ------------------------------------------------------------------------
  // Address map and register layout
  // ------------------------------------------------------------------------
  localparam int         ADDR_W              = 20;
  localparam logic [19:0] REFRESH_OFFSET     = 20'h001AD;
  localparam logic [7:0]  REFRESH_RESET      = 8'h00;
  localparam int          REFRESH_FIELD_W    = 6;
  localparam logic [19:0] BLOCK1_START       = 20'h0F000;
  localparam logic [19:0] BLOCK2_START       = 20'h0E000;
  localparam logic [19:0] BLOCK_SIZE         = 20'h01000;
  localparam logic [19:0] DATA_A_START       = 20'h03000;
  localparam logic [19:0] DATA_B_START       = 20'h03400;
  localparam logic [19:0] DATA_BLOCK_SIZE    = 20'h00400;

  // Status register bit positions.
  localparam int STAT_READY_BIT   = 7;
  localparam int STAT_ERASE_BIT   = 5;
  localparam int STAT_PROGRAM_BIT = 4;
  localparam int STAT_LOCK_BIT    = 2;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;

  // ------------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int PROGRAM_TIME_NS  = 400;
  localparam int PROGRAM_CYCLES   = (PROGRAM_TIME_NS * CLK_MHZ) / 1000;
  localparam int OP_CYCLES        = 16;

  // ------------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_READ_ARRAY = 3'b000,
    ST_WAIT_DATA  = 3'b001,
    ST_WAIT_CONF  = 3'b010,
    ST_BUSY       = 3'b011,
    ST_SUSPENDED  = 3'b100
  } fcs_state_type;

endpackage

// ### hw/fcs_if.sv
// Interface joining the CPU-side command master to the flash sequencer.
`timescale 1ns/1ps
interface fcs_if;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [19:0] addr;
  logic [7:0]  wrData;
  logic [7:0]  rdData;
  logic        rdValid;
  logic        readyIrq;

  modport device (
    input  wrStrobe,
    input  rdStrobe,
    input  addr,
    input  wrData,
    output rdData,
    output rdValid,
    output readyIrq
  );

  modport host (
    output wrStrobe,
    output rdStrobe,
    output addr,
    output wrData,
    input  rdData,
    input  rdValid,
    input  readyIrq
  );
endinterface

// ### hw/fcs_op_timer.sv
// Down counter that times one flash operation and reports its end.
`timescale 1ns/1ps
module fcs_op_timer #(
  parameter int CYCLES = 100
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic hold,
  output logic      done
);
  logic [15:0] countReg;

  // ------------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------------
  // Hold freezes the count so a suspended operation resumes where it was.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      countReg <= 16'h0000;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        countReg <= 16'(CYCLES);
      end
      else if (countReg != 16'h0000 && !hold)
      begin
        countReg <= countReg - 16'h0001;
        done     <= (countReg == 16'h0001);
      end
    end
  end
endmodule // fcs_op_timer

// ### hw/fcs_host.sv
// CPU-side command master: turns user requests into command write and read cycles.
`timescale 1ns/1ps
module fcs_host (
  input  wire logic        clk,
  input  wire logic        rst_b,
  fcs_if.host              bus,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [19:0] reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             reqReady,
  output logic [7:0]       respData,
  output logic             respValid,
  output logic             irqSeen
);
  // ------------------------------------------------------------------------
  // Request driver
  // ------------------------------------------------------------------------
  // One request per cycle; sequencing of codes is left to the user side.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bus.wrStrobe <= 1'b0;
      bus.rdStrobe <= 1'b0;
      bus.addr     <= 20'h00000;
      bus.wrData   <= 8'h00;
      reqReady     <= 1'b0;
    end
    else
    begin
      reqReady     <= 1'b1;
      bus.wrStrobe <= reqValid && reqReady && reqWrite;
      bus.rdStrobe <= reqValid && reqReady && !reqWrite;
      if (reqValid && reqReady)
      begin
        bus.addr   <= reqAddr;
        bus.wrData <= reqData;
      end
    end
  end

  // ------------------------------------------------------------------------
  // Response capture
  // ------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      respData  <= 8'h00;
      respValid <= 1'b0;
      irqSeen   <= 1'b0;
    end
    else
    begin
      respValid <= bus.rdValid;
      respData  <= bus.rdData;
      irqSeen   <= bus.readyIrq;
    end
  end
endmodule // fcs_host

// ### testbench/fcs_assertions.sv
// Concurrent checks on the link between the command master and the flash sequencer, and on the sequencer busy and status outputs.
`timescale 1ns/1ps
module fcs_assertions (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire logic [19:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic       rdValid,
  input wire logic       readyIrq,
  input wire logic       readyIrqEnable,
  input wire logic       busy,
  input wire logic [7:0] flashStatus
);
  // ------------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------------
  // All checks share one clock; reset masks them because outputs are forced then.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  read_answer_a: assert property (rdStrobe |=> rdValid)
    else $error("read strobe got no answer one cycle later");
  read_cause_a: assert property (rdValid |-> $past(rdStrobe))
    else $error("read answer without a read strobe");
  irq_enable_a: assert property (readyIrq |-> $past(readyIrqEnable))
    else $error("ready interrupt while disabled");
  irq_pulse_a: assert property (readyIrq |=> !readyIrq)
    else $error("ready interrupt longer than one cycle");
  ready_low_a: assert property ($rose(busy) |-> ##[0:1] !flashStatus[7])
    else $error("ready flag high when operation starts");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("operation ended too early");
  ready_return_a: assert property ($fell(busy) |-> ##[0:2] flashStatus[7])
    else $error("ready flag not set after operation");
  status_clear_a: assert property (wrStrobe && wrData == 8'h50 && !busy
      |-> ##[1:3] flashStatus[5:4] == 2'b00)
    else $error("result flags not cleared");
  refresh_upper_a: assert property (rdStrobe && addr == 20'h001AD
      |=> rdData[7:6] == 2'b00)
    else $error("refresh register upper bits not zero");
endmodule // fcs_assertions

// ### testbench/testbench.sv
// Self-checking testbench for the command master and flash sequencer pair.
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------------
  logic        clk;
  logic        rst_b;
  logic        reqValid;
  logic        reqWrite;
  logic [19:0] reqAddr;
  logic [7:0]  reqData;
  logic        reqReady;
  logic [7:0]  respData;
  logic        respValid;
  logic        irqSeen;
  logic        protA;
  logic        protB;
  logic        irqEn;
  logic        suspEn;
  logic        suspReq;
  logic        lowRead;
  logic [7:0]  flashStatus;
  logic        busy;
  logic        refreshActive;
  logic [7:0]  rdVal;
  int          badCount = 0;
  int          checked = 0;
  int          irqCount = 0;
  int          irqBase;

  fcs_if link ();

  fcs_device #(.PROG_CYCLES(100)) i_fcs_device (.clk(clk), .rst_b(rst_b), .bus(link),
    .dataBlockAProtect(protA), .dataBlockBProtect(protB), .readyIrqEnable(irqEn),
    .suspendEnable(suspEn), .suspendRequest(suspReq), .lowCurrentReadEnable(lowRead),
    .flashStatus(flashStatus), .busy(busy), .refreshActive(refreshActive));

  fcs_host i_fcs_host (.clk(clk), .rst_b(rst_b), .bus(link), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .respData(respData), .respValid(respValid), .irqSeen(irqSeen));

  fcs_assertions i_fcs_assertions (.clk(clk), .rst_b(rst_b), .wrStrobe(link.wrStrobe),
    .rdStrobe(link.rdStrobe), .addr(link.addr), .wrData(link.wrData), .rdData(link.rdData),
    .rdValid(link.rdValid), .readyIrq(link.readyIrq), .readyIrqEnable(irqEn), .busy(busy),
    .flashStatus(flashStatus));

  // Free-running 250 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts interrupts seen by the master; pulses are too short to poll reliably.
  always @(posedge clk)
  begin
    if (irqSeen === 1'b1) irqCount <= irqCount + 1;
  end

  // ------------------------------------------------------------------------
  // Helper tasks
  // ------------------------------------------------------------------------
  task automatic finalReport();
    if (badCount == 0 && checked > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic giveUp(input string name);
    badCount++;
    $display("[ERR] %s expected completion seen timeout", name);
    finalReport();
  endtask

  // Holds the request from one falling edge until a rising edge with ready high.
  task automatic req(input logic w, input logic [19:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    n = 0;
    while (reqReady !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 50) giveUp("request");
    end
    @(negedge clk);
    reqValid = 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    int n;
    req(1'b0, a, 8'h00);
    n = 0;
    while (respValid !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 50) giveUp("read");
    end
    d = respData;
  endtask

  // Watches for an operation to start, then waits for it to finish.
  task automatic op(input logic expBusy, input string name);
    logic seen;
    int   n;
    seen = 1'b0;
    for (n = 0; n < 8; n++)
    begin
      @(negedge clk);
      if (busy === 1'b1) seen = 1'b1;
    end
    n = 0;
    while (busy !== 1'b0)
    begin
      @(negedge clk);
      n++;
      if (n > 400) giveUp(name);
    end
    repeat (4) @(negedge clk);
    check(name, {7'h00, expBusy}, {7'h00, seen});
  endtask

  // ------------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------------
  // Low-current read is off whenever the interval is rewritten.
  task automatic refreshTest();
    lowRead = 1'b0;
    req(1'b1, fcs_pkg::REFRESH_OFFSET, 8'h3F);
    repeat (2) @(negedge clk);
    lowRead = 1'b1;
    repeat (4) @(negedge clk);
    check("refresh active", 8'h01, {7'h00, refreshActive});
    rd(fcs_pkg::REFRESH_OFFSET, rdVal);
    check("refresh readback", 8'h3F, rdVal);
    lowRead = 1'b0;
    req(1'b1, fcs_pkg::REFRESH_OFFSET, 8'hC0);
    repeat (2) @(negedge clk);
    lowRead = 1'b1;
    repeat (4) @(negedge clk);
    check("refresh upper bits", 8'h00, {7'h00, refreshActive});
    rd(fcs_pkg::REFRESH_OFFSET, rdVal);
    check("refresh upper read", 8'h00, rdVal);
  endtask

  task automatic programTest();
    irqBase = irqCount;
    req(1'b1, fcs_pkg::BLOCK1_START, 8'hFF);
    req(1'b1, fcs_pkg::BLOCK1_START + 20'h00010, 8'h40);
    req(1'b1, fcs_pkg::BLOCK1_START + 20'h00010, 8'h5A);
    op(1'b1, "program busy");
    check("program status", 8'h80, flashStatus & 8'h90);
    check("program irq", 8'h01, 8'(irqCount - irqBase));
    rd(fcs_pkg::BLOCK1_START + 20'h00010, rdVal);
    check("array read", 8'h5A, rdVal);
    rd(fcs_pkg::BLOCK1_START + 20'h00010, rdVal);
    check("array reread", 8'h5A, rdVal);
  endtask

  // Adding bits to a programmed byte must show as a failed program.
  task automatic failTest();
    req(1'b1, fcs_pkg::BLOCK1_START + 20'h00010, 8'h40);
    req(1'b1, fcs_pkg::BLOCK1_START + 20'h00010, 8'hA5);
    op(1'b1, "reprogram busy");
    check("program fail flag", 8'h10, flashStatus & 8'h10);
    req(1'b1, fcs_pkg::BLOCK1_START, 8'h50);
    repeat (4) @(negedge clk);
    check("status cleared", 8'h00, flashStatus & 8'h30);
  endtask

  task automatic undefTest();
    req(1'b1, fcs_pkg::BLOCK1_START, 8'h33);
    op(1'b0, "undefined code");
    rd(fcs_pkg::BLOCK1_START + 20'h00020, rdVal);
    check("read mode kept", 8'hFF, rdVal);
  endtask

  task automatic protectTest();
    int          i;
    logic [19:0] base;
    for (i = 0; i < 2; i++)
    begin
      protA = (i == 0);
      protB = (i == 1);
      irqBase = irqCount;
      base = (i == 0) ? fcs_pkg::DATA_A_START : fcs_pkg::DATA_B_START;
      req(1'b1, base + 20'h00020, 8'h40);
      req(1'b1, base + 20'h00020, 8'h00);
      op(1'b0, "protected program");
      check("protected irq", 8'h00, 8'(irqCount - irqBase));
    end
    protA = 1'b0;
    protB = 1'b0;
  endtask

  task automatic lockTest();
    req(1'b1, fcs_pkg::BLOCK2_START, 8'h71);
    req(1'b1, fcs_pkg::BLOCK2_START, 8'hD0);
    op(1'b1, "lock read");
    check("unlocked status", 8'h04, flashStatus & 8'h04);
    req(1'b1, fcs_pkg::BLOCK1_START, 8'h77);
    req(1'b1, fcs_pkg::BLOCK1_START, 8'hD0);
    op(1'b1, "lock program");
    req(1'b1, fcs_pkg::BLOCK1_START, 8'h71);
    req(1'b1, fcs_pkg::BLOCK1_START, 8'hD0);
    op(1'b1, "lock read");
    check("locked status", 8'h00, flashStatus & 8'h04);
    req(1'b1, fcs_pkg::BLOCK1_START + 20'h00030, 8'h40);
    req(1'b1, fcs_pkg::BLOCK1_START + 20'h00030, 8'h00);
    op(1'b0, "locked program");
    req(1'b1, fcs_pkg::DATA_A_START, 8'h77);
    req(1'b1, fcs_pkg::DATA_A_START, 8'hD0);
    op(1'b0, "data flash lock");
  endtask

  // Suspend mid-program; the interrupt must come at entry, not only at completion.
  task automatic suspendTest();
    suspEn = 1'b1;
    req(1'b1, fcs_pkg::BLOCK2_START + 20'h00040, 8'h40);
    req(1'b1, fcs_pkg::BLOCK2_START + 20'h00040, 8'h00);
    repeat (10) @(negedge clk);
    irqBase = irqCount;
    suspReq = 1'b1;
    repeat (10) @(negedge clk);
    check("suspend irq", 8'h01, 8'(irqCount - irqBase));
    check("suspend ready", 8'h80, flashStatus & 8'h80);
    suspReq = 1'b0;
    op(1'b1, "resume busy");
    suspEn = 1'b0;
  endtask

  // With the interrupt masked a finished program must stay silent.
  task automatic irqOffTest();
    irqEn = 1'b0;
    irqBase = irqCount;
    req(1'b1, fcs_pkg::BLOCK2_START + 20'h00050, 8'h40);
    req(1'b1, fcs_pkg::BLOCK2_START + 20'h00050, 8'h00);
    op(1'b1, "masked program busy");
    check("masked irq", 8'h00, 8'(irqCount - irqBase));
    irqEn = 1'b1;
  endtask

  task automatic eraseTest();
    req(1'b1, fcs_pkg::BLOCK2_START, 8'h20);
    req(1'b1, fcs_pkg::BLOCK2_START, 8'hFF);
    op(1'b0, "erase cancel");
    check("cancel status", 8'h00, flashStatus & 8'h30);
    req(1'b1, fcs_pkg::BLOCK2_START, 8'h20);
    req(1'b1, fcs_pkg::BLOCK2_START + 20'h00100, 8'hD0);
    op(1'b1, "block erase");
    req(1'b1, fcs_pkg::BLOCK2_START, 8'h25);
    req(1'b1, fcs_pkg::BLOCK2_START + 20'h00200, 8'hD0);
    op(1'b1, "blank check");
    check("erase flag", 8'h80, flashStatus & 8'hA0);
  endtask

  // ------------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 20'h00000;
    reqData = 8'h00;
    protA = 1'b0;
    protB = 1'b0;
    irqEn = 1'b1;
    suspEn = 1'b0;
    suspReq = 1'b0;
    lowRead = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check("reset status", 8'h80, flashStatus);
    refreshTest();
    programTest();
    failTest();
    undefTest();
    protectTest();
    lockTest();
    suspendTest();
    irqOffTest();
    eraseTest();
    finalReport();
  end
endmodule // testbench
